// *** rtl/lmsc_top.sv ***
// Purpose: Scan controller for a multiplexed LED array behind a Wishbone slave.
// Assumes: clk_i is the fast internal oscillator; reset is synchronous, active high.
// Notes:   Pins are two signals each, level and enable; the pad logic resolves the wire.
`timescale 1ns/1ns
`default_nettype none
`include "lmsc_cfg.svh"
module lmsc_top
    import lmsc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [7:0]       common_line_o,
    output logic [7:0]       common_line_oe_o,
    output logic [7:0]       segment_line_o,
    output logic [7:0]       segment_line_oe_o
);
    logic [7:0]  scan_ctl_q;          // Scan control register.
    logic [7:0]  brit_ctl_q;          // Brightness control register.
    logic [7:0]  led_data_q [0:7];    // LED on/off bits, eight LEDs per byte.
    logic        ack_q;               // Bus acknowledge.
    logic [31:0] rdata_q;             // Registered read data.
    logic [5:0]  pre_q;               // Prescaler counter.
    logic [2:0]  step_q;              // Brightness step within a slot.
    logic [3:0]  slot_q;              // Current scan slot.
    lmsc_mode_e  mode_q;              // Mode being scanned.
    lmsc_mode_e  mode_d;              // Mode the registers ask for.
    logic [5:0]  tc;                  // Selected prescaler terminal count.
    logic [3:0]  nslots;              // Slots per frame in the scanned mode.
    logic [3:0]  nseg;                // Segment lines used in matrix mode.
    logic        tick;                // One-cycle scan clock enable.
    logic        req;                 // New bus request this cycle.
    logic [7:0]  idx;                 // Word index of the access.
    logic [7:0]  com_d;               // Next common line levels.
    logic [7:0]  com_oe_d;            // Next common line enables.
    logic [7:0]  seg_d;               // Next segment line levels.
    logic [7:0]  seg_oe_d;            // Next segment line enables.
    logic [7:0]  on;                  // Per sink line: drive now.
    logic        seg_slot;            // Matrix slot scans a segment line.
    logic [3:0]  sidx;                // Segment index of a segment slot.

    assign idx = wb_adr_i[9:2];
    // A request is new only while no acknowledge is out, so each access acks once.
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    // Decode the asked mode; dot matrix takes priority when both are enabled.
    always_comb
    begin
        if (brit_ctl_q[`LMSC_DMXEN])
            mode_d = LMSC_MODE_DMX;
        else if (scan_ctl_q[`LMSC_DUTY] != `LMSC_DUTY_OFF)
            mode_d = LMSC_MODE_BID;
        else
            mode_d = LMSC_MODE_OFF;
    end

    // Segment count follows the duty code; frame length does too outside dot-matrix mode.
    always_comb
    begin
        case (scan_ctl_q[`LMSC_DUTY])
            `LMSC_DUTY_8:  nseg = 4'h4;
            `LMSC_DUTY_9:  nseg = 4'h5;
            `LMSC_DUTY_10: nseg = 4'h6;
            default:       nseg = 4'h0;
        endcase
        if (mode_q == LMSC_MODE_DMX)
            nslots = `LMSC_DMX_SLOTS;
        else
            nslots = `LMSC_COMS + nseg;
    end

    // Prescaler terminal count selection.
    always_comb
    begin
        case (scan_ctl_q[`LMSC_PSC])
            2'h0:    tc = `LMSC_TC_64;
            2'h1:    tc = `LMSC_TC_32;
            2'h2:    tc = `LMSC_TC_16;
            default: tc = `LMSC_TC_8;
        endcase
    end

    // The freeze bit stops the scan clock; the counter also holds so it resumes in phase.
    assign tick = (pre_q >= tc) & ~scan_ctl_q[`LMSC_HOLD] & (mode_q != LMSC_MODE_OFF);

    // Prescaler counter; a shortened terminal count is caught by the compare.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || mode_q == LMSC_MODE_OFF)
            pre_q <= 6'h00;
        else if (scan_ctl_q[`LMSC_HOLD])
            pre_q <= pre_q;
        else if (pre_q >= tc)
            pre_q <= 6'h00;
        else
            pre_q <= pre_q + 6'h01;
    end

    // Mode tracker; a mode change restarts the frame so no slot runs out of range.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_q <= LMSC_MODE_OFF;
        else
            mode_q <= mode_d;
    end

    // Step and slot counters advance on the scan clock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || mode_d != mode_q)
        begin
            step_q <= 3'h0;
            slot_q <= 4'h0;
        end
        else if (slot_q >= nslots)
        begin
            // A shorter geometry written mid-frame leaves the slot past the end, so restart.
            step_q <= 3'h0;
            slot_q <= 4'h0;
        end
        else if (tick)
        begin
            step_q <= step_q + 3'h1;
            if (step_q == `LMSC_STEP_LAST)
            begin
                if (slot_q >= nslots - 4'h1)
                    slot_q <= 4'h0;
                else
                    slot_q <= slot_q + 4'h1;
            end
        end
    end

    assign seg_slot = (slot_q >= `LMSC_COMS);
    assign sidx     = slot_q - `LMSC_COMS;

    // Per sink line: LED number, its bit, its brightness group and the gate.
    genvar j;
    generate
        for (j = 0; j < 8; j++)
        begin : g_line
            logic [5:0] num;      // LED number on this line in this slot.
            lmsc_lvl_t  lvl;      // Brightness level for that LED.
            logic       lit;      // LED is set on and exists.
            always_comb
            begin
                if (mode_q == LMSC_MODE_DMX)
                begin
                    num = {slot_q[2:0], 3'(j)};
                    lvl = brit_ctl_q[`LMSC_SECOND];
                    lit = 1'b1;
                end
                else if (seg_slot)
                begin
                    num = `LMSC_SEG_BASE + {sidx[3:0], 2'(j)};
                    lit = (j < 4);
                    if (num >= `LMSC_GRP_LO && num <= `LMSC_GRP_HI)
                        lvl = num[0] ? brit_ctl_q[`LMSC_SECOND]
                                     : brit_ctl_q[`LMSC_FIRST];
                    else
                        lvl = scan_ctl_q[`LMSC_MAIN];
                end
                else
                begin
                    num = {slot_q[2:0], 3'(j)};
                    lit = (4'(j) < nseg);
                    lvl = scan_ctl_q[`LMSC_MAIN];
                end
                lit = lit & led_data_q[num[5:3]][num[2:0]];
            end
            lmsc_bright_gate u_gate
            (
                .level_i (lvl),
                .step_i  (step_q),
                .boost_i (brit_ctl_q[`LMSC_STYLE]),
                .lit_i   (lit),
                .on_o    (on[j])
            );
        end
    endgenerate

    // Pin drive pattern; the pins must already be in LED function mode.
    always_comb
    begin
        com_d    = 8'h00;
        com_oe_d = 8'h00;
        seg_d    = 8'h00;
        seg_oe_d = 8'h00;
        case (mode_q)
            LMSC_MODE_DMX:
            begin
                // Row high on the scanned common; segments sink for lit dots.
                com_oe_d = 8'hFF;
                com_d[slot_q[2:0]] = 1'b1;
                seg_oe_d = 8'hFF;
                seg_d    = ~on;
            end
            LMSC_MODE_BID:
            begin
                // One line sources; the far ends of lit LEDs sink, others float.
                if (slot_q >= nslots)
                begin
                    // Stale slot outside the new geometry: float every line for that cycle.
                    com_d = 8'h00;
                end
                else if (seg_slot)
                begin
                    seg_oe_d[sidx[2:0]] = 1'b1;
                    seg_d[sidx[2:0]]    = 1'b1;
                    com_oe_d            = on & 8'h0F;
                end
                else
                begin
                    com_oe_d[slot_q[1:0]] = 1'b1;
                    com_d[slot_q[1:0]]    = 1'b1;
                    seg_oe_d              = on;
                end
            end
            default:
            begin
                // Scanning off: every line floats.
                com_d = 8'h00;
            end
        endcase
    end

    // Pin outputs come from flip-flops so no glitch reaches an LED.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            common_line_o     <= 8'h00;
            common_line_oe_o  <= 8'h00;
            segment_line_o    <= 8'h00;
            segment_line_oe_o <= 8'h00;
        end
        else
        begin
            common_line_o     <= com_d;
            common_line_oe_o  <= com_oe_d;
            segment_line_o    <= seg_d;
            segment_line_oe_o <= seg_oe_d;
        end
    end

    // Control register writes; only byte lane 0 carries register data.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_ctl_q <= `LMSC_SCAN_RST;
            brit_ctl_q <= `LMSC_BRIT_RST;
        end
        else if (req && wb_we_i && wb_sel_i[0])
        begin
            if (idx == `LMSC_IDX_SCAN)
                scan_ctl_q <= wb_dat_i[7:0];
            if (idx == `LMSC_IDX_BRIT)
                brit_ctl_q <= wb_dat_i[7:0];
        end
    end

    // LED data bytes; they power up dark.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int k = 0; k < 8; k++)
                led_data_q[k] <= 8'h00;
        end
        else if (req && wb_we_i && wb_sel_i[0] && idx[7:3] == `LMSC_IDX_DATA)
            led_data_q[idx[2:0]] <= wb_dat_i[7:0];
    end

    // Acknowledge one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    // Read mux; unmapped words read zero and still acknowledge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h0000_0000;
        else if (req)
        begin
            if (idx == `LMSC_IDX_SCAN)
                rdata_q <= {24'h000000, scan_ctl_q};
            else if (idx == `LMSC_IDX_BRIT)
                rdata_q <= {24'h000000, brit_ctl_q};
            else if (idx == `LMSC_IDX_STAT)
                rdata_q <= {24'h000000, mode_q, step_q[2:1], slot_q};
            else if (idx[7:3] == `LMSC_IDX_DATA)
                rdata_q <= {24'h000000, led_data_q[idx[2:0]]};
            else
                rdata_q <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
endmodule
`default_nettype wire

// *** inc/lmsc_cfg.svh ***
// Purpose: Named constants for the LED matrix scan controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Register indices are word indices; byte address is four times the index.
`ifndef LMSC_CFG_SVH
`define LMSC_CFG_SVH

// Register word indices on the bus.
`define LMSC_IDX_SCAN    8'hB1
`define LMSC_IDX_BRIT    8'hB2
`define LMSC_IDX_STAT    8'hB3
`define LMSC_IDX_DATA    5'h18
// Reset values of the two control registers.
`define LMSC_SCAN_RST    8'h07
`define LMSC_BRIT_RST    8'h77
// Field positions in the scan control register.
`define LMSC_DUTY        7:6
`define LMSC_PSC         5:4
`define LMSC_HOLD        3
`define LMSC_MAIN        2:0
// Field positions in the brightness control register.
`define LMSC_STYLE       7
`define LMSC_SECOND      6:4
`define LMSC_DMXEN       3
`define LMSC_FIRST       2:0
// Duty codes.
`define LMSC_DUTY_OFF    2'h0
`define LMSC_DUTY_8      2'h1
`define LMSC_DUTY_9      2'h2
`define LMSC_DUTY_10     2'h3
// Prescaler terminal counts (divisor minus one).
`define LMSC_TC_64       6'h3F
`define LMSC_TC_32       6'h1F
`define LMSC_TC_16       6'h0F
`define LMSC_TC_8        6'h07
// Scan geometry.
`define LMSC_COMS        4'h4
`define LMSC_DMX_SLOTS   4'h8
`define LMSC_STEP_LAST   3'h7
`define LMSC_SEG_BASE    6'h20
`define LMSC_GRP_LO      6'h20
`define LMSC_GRP_HI      6'h27

`endif

// *** inc/lmsc_pkg.sv ***
// Purpose: Types shared by the LED matrix scan controller files.
// Assumes: Constants live in lmsc_cfg.svh.
// Notes:   Holds types only.
package lmsc_pkg;
    // Scan mode of the controller.
    typedef enum logic [1:0]
    {
        LMSC_MODE_OFF = 2'b00,
        LMSC_MODE_BID = 2'b01,
        LMSC_MODE_DMX = 2'b10
    } lmsc_mode_e;
    // A three-bit brightness level.
    typedef logic [2:0] lmsc_lvl_t;
endpackage

// *** rtl/lmsc_bright_gate.sv ***
// Purpose: Decides whether a lit LED is driven in the current step of its slot.
// Assumes: Step counts 0..7 within one scan slot.
// Notes:   Purely combinational; one instance per sink line.
`timescale 1ns/1ns
`default_nettype none
module lmsc_bright_gate
    import lmsc_pkg::*;
(
    input  wire lmsc_lvl_t  level_i,
    input  wire logic [2:0] step_i,
    input  wire logic       boost_i,
    input  wire logic       lit_i,
    output logic            on_o
);
    // Uniform mode drives level+1 of eight steps; boost adds one step, capped at full slot.
    always_comb
    begin
        if (boost_i)
            on_o = lit_i & ({1'b0, step_i} <= ({1'b0, level_i} + 4'h1));
        else
            on_o = lit_i & (step_i <= level_i);
    end
endmodule
`default_nettype wire

// *** testbench/lmsc_chk.sv ***
// Purpose: Port-level assertions for the LED matrix scan controller.
// Assumes: Shadows both control registers from accepted bus writes.
// Notes:   Pin checks wait a few cycles after a write for the pin pipeline.
`timescale 1ns/1ns
`default_nettype none
`include "lmsc_cfg.svh"
module lmsc_chk
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [7:0]  common_line_o,
    input  wire logic [7:0]  common_line_oe_o,
    input  wire logic [7:0]  segment_line_o,
    input  wire logic [7:0]  segment_line_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] scan_q;  // Shadow of the scan control register.
    logic [7:0] brit_q;  // Shadow of the brightness control register.
    logic [1:0] age_q;   // Cycles since the last write, saturating at 3.
    logic       take;    // A request is taken on this edge.
    logic       dot_matrix_mode;     // Dot-matrix mode selected.
    logic       bidirectional_matrix_mode;     // Bidirectional matrix mode selected.
    logic       off;     // No scanning at all.
    logic [3:0] nseg;    // Segment count of the matrix geometry.
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign dot_matrix_mode  = brit_q[3];
    assign bidirectional_matrix_mode  = !dot_matrix_mode && (scan_q[7:6] != 2'h0);
    assign off  = !dot_matrix_mode && (scan_q[7:6] == 2'h0);
    assign nseg = {2'h0, scan_q[7:6]} + 4'h3;
    // Mirror writes on the edge the design takes them, so no lag creeps in.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_q <= `LMSC_SCAN_RST;
            brit_q <= `LMSC_BRIT_RST;
            age_q  <= 2'h0;
        end
        else if (take && wb_we_i)
        begin
            age_q <= 2'h0;
            if (wb_sel_i[0] && wb_adr_i[9:2] == `LMSC_IDX_SCAN)
                scan_q <= wb_dat_i[7:0];
            if (wb_sel_i[0] && wb_adr_i[9:2] == `LMSC_IDX_BRIT)
                brit_q <= wb_dat_i[7:0];
        end
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_off_float: assert property (off [*4] |-> (common_line_oe_o | segment_line_oe_o) == 8'h00)
        else $error("pins driven while scanning is off");
    a_dot_drive: assert property (dot_matrix_mode [*4] |-> (common_line_oe_o & segment_line_oe_o) == 8'hFF)
        else $error("dot lines not all driven");
    a_dot_onecom: assert property (dot_matrix_mode [*4] |-> $onehot(common_line_o))
        else $error("dot mode common not one-hot");
    a_bid_range: assert property (bidirectional_matrix_mode && age_q == 2'h3 |-> common_line_oe_o[7:4] == 4'h0
        && (segment_line_oe_o >> nseg) == 8'h00) else $error("matrix line outside geometry");
    a_bid_onehigh: assert property (bidirectional_matrix_mode [*4] |-> $onehot0({common_line_o & common_line_oe_o,
        segment_line_o & segment_line_oe_o})) else $error("two matrix lines high");
    a_freeze_hold: assert property (scan_q[3] && age_q == 2'h3 |=> $stable(common_line_o)
        && $stable(segment_line_o)) else $error("pins moved while frozen");
    c_dot: cover property (dot_matrix_mode && age_q == 2'h3);
    c_bid: cover property (bidirectional_matrix_mode && age_q == 2'h3);
    c_hold: cover property (scan_q[3] && age_q == 2'h3);
endmodule
bind lmsc_top lmsc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .common_line_o(common_line_o), .common_line_oe_o(common_line_oe_o),
    .segment_line_o(segment_line_o), .segment_line_oe_o(segment_line_oe_o));
`default_nettype wire

// *** testbench/lmsc_led_model.sv ***
// Purpose: Passive LED array on the common and segment lines.
// Assumes: An LED conducts when its anode drives high and its cathode sinks.
// Notes:   A dot array has no reverse-wired LEDs, so dot_i masks them.
`timescale 1ns/1ns
`default_nettype none
module lmsc_led_model
(
    input  wire logic [7:0] com_i,
    input  wire logic [7:0] com_oe_i,
    input  wire logic [7:0] seg_i,
    input  wire logic [7:0] seg_oe_i,
    input  wire logic       dot_i,
    output logic [63:0]     glow_o
);
    // Floating lines carry no current, so only enabled lines count.
    always_comb
    begin
        glow_o = 64'h0;
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 8; k++)
            begin
                if (com_oe_i[c] && com_i[c] && seg_oe_i[k] && !seg_i[k])
                    glow_o[c*8+k] = 1'b1;
                if (!dot_i && c < 4 && k < 6 && seg_oe_i[k] && seg_i[k] && com_oe_i[c] && !com_i[c])
                    glow_o[32+4*k+c] = 1'b1;
            end
    end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: Register and scan-timing tests of the LED matrix scan controller.
// Assumes: 10 MHz clock; LED on-time is counted over one whole frame.
// Notes:   Frames are periodic, so any window of one frame gives exact counts.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk_i;
    logic        rst_i;
    logic [9:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
    logic [31:0] rdat;
    logic        ack;
    logic [7:0]  common_line;
    logic [7:0]  com_oe;
    logic [7:0]  segment_line;
    logic [7:0]  seg_oe;
    logic [63:0] glow;
    logic        dot;
    int          miscompares;
    int          cmp_count;
    int          cnt [64];
    lmsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .common_line_o(common_line), .common_line_oe_o(com_oe), .segment_line_o(segment_line), .segment_line_oe_o(seg_oe));
    lmsc_led_model u_leds (.com_i(common_line), .com_oe_i(com_oe), .seg_i(segment_line), .seg_oe_i(seg_oe), .dot_i(dot),
        .glow_o(glow));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // One classic cycle; request held until ack is sampled, then one idle cycle.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0,
        output logic [31:0] q);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        sel <= {3'h0, s0};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n >= 20)
        begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, 1'b1, q);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 1'b1, q);
        check(nm, {24'h0, e}, q);
    endtask
    // Count on-cycles of every LED across one frame of len clocks.
    task automatic measure(input int len);
        repeat (4) @(posedge clk_i);
        foreach (cnt[i]) cnt[i] = 0;
        repeat (len)
        begin
            @(posedge clk_i);
            foreach (cnt[i]) cnt[i] += (glow[i] === 1'b1) ? 1 : 0;
        end
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        logic [31:0] q;
        int          ok;
        int          n;
        {rst_i, cyc, stb, we, adr, wdat, sel, dot} = {1'b1, 50'h0};
        miscompares = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk("scan reset", 8'hB1, 8'h07);
        rdchk("brit reset", 8'hB2, 8'h77);
        wr(8'h10, 8'hAA);
        rdchk("unmapped", 8'h10, 8'h00);
        bus(1'b1, 8'hB1, 8'hFF, 1'b0, q);
        rdchk("no sel", 8'hB1, 8'h07);
        // Pins are taken to be in LED function before any mode is enabled.
        for (int i = 0; i < 8; i++) wr(8'hC0 + 8'(i), 8'hFF);
        wr(8'hB2, 8'h64);
        for (int d = 1; d < 4; d++)
        begin
            n = d + 3;
            wr(8'hB1, {2'(d), 6'h32});
            measure((4 + n) * 64);
            check("led 0", 24, cnt[0]);
            check("last seg", 24, cnt[n-1]);
            check("past seg", 0, cnt[n]);
            check("led 40", 24, cnt[40]);
            check("led 32", 40, cnt[32]);
            check("led 33", 56, cnt[33]);
        end
        for (int p = 0; p < 4; p++)
        begin
            wr(8'hB1, {2'h1, 2'(p), 4'h3});
            measure(64 * (64 >> p));
            check("prescale", 4 * (64 >> p), cnt[0]);
        end
        for (int s = 0; s < 2; s++)
            for (int l = 0; l < 8; l++)
            begin
                wr(8'hB2, {1'(s), 7'h64});
                wr(8'hB1, {5'h0E, 3'(l)});
                measure(512);
                check("level", (s == 1 && l < 7 ? l + 2 : l + 1) * 8, cnt[0]);
            end
        wr(8'hB1, 8'h7F);
        measure(512);
        ok = 1;
        foreach (cnt[i]) if (cnt[i] != 0 && cnt[i] != 512) ok = 0;
        check("frozen", 1, ok);
        wr(8'hB1, 8'h77);
        measure(512);
        check("resumed", 64, cnt[0]);
        wr(8'hC7, 8'h7F);
        rdchk("led byte", 8'hC7, 8'h7F);
        wr(8'hB2, 8'h38);
        dot <= 1'b1;
        measure(512);
        check("dot led 0", 32, cnt[0]);
        check("dot led 36", 32, cnt[36]);
        check("dot unlit", 0, cnt[63]);
        wr(8'hB2, 8'h30);
        wr(8'hB1, 8'h07);
        dot <= 1'b0;
        measure(512);
        check("off", 0, cnt[0]);
        rdchk("status off", 8'hB3, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
